// >>> rtl/pif_pkg.sv
// Operation
// - Fixed vector pairs FFFE down to FFF0
// - Mask blocks all but non-maskable and trap
// - Reset sets the mask bit
// - Mask sets at once, clears one cycle late
// - Enables clear at reset, written in E phase
// - Six enables gate the sources
// - Flag requests only when enabled and unmasked
// - External pin latch held while unmasked
// - Non-maskable falling edge sets request flip-flop
// - Strobe falling edge sets strobe flag
// - Capture flag sets two cycles after edge
// - Compare flag sets one cycle after match
// - Overflow flag sets when counter reads all ones
// - Receive-full sets when character latched
// - Overrun/framing sets when error detected
// - Transmit-empty sets when shift register loaded
// - Non-maskable request clears at entry cycle ten
// - Serial flags armed at 0x11, cleared 0x12/0x13
// - Strobe armed at 0x0F, cleared at 0x06
// - Capture armed at 0x08, cleared reading 0x0D
// - Compare cleared 0x0B/0x0C, overflow reading 0x09
// - Request path is level sensitive
// - Twelve-cycle entry, group ninth, source tenth
// - Mask sets at entry cycle ten
// - Empty internal entry selects serial vector
package pif_pkg;
  localparam logic [7:0] OFS_PORT3_VALUE   = 8'h06;
  localparam logic [7:0] OFS_TIMER_CS      = 8'h08;
  localparam logic [7:0] OFS_COUNT         = 8'h09;
  localparam logic [7:0] OFS_COMPARE_HI    = 8'h0b;
  localparam logic [7:0] OFS_COMPARE_LO    = 8'h0c;
  localparam logic [7:0] OFS_CAPTURE       = 8'h0d;
  localparam logic [7:0] OFS_PORT3_CS      = 8'h0f;
  localparam logic [7:0] OFS_SERIAL_CS     = 8'h11;
  localparam logic [7:0] OFS_RX_BUFFER     = 8'h12;
  localparam logic [7:0] OFS_TX_BUFFER     = 8'h13;

  localparam logic [15:0] VEC_RESET   = 16'hfffe;
  localparam logic [15:0] VEC_NMI     = 16'hfffc;
  localparam logic [15:0] VEC_TRAP    = 16'hfffa;
  localparam logic [15:0] VEC_EXT     = 16'hfff8;
  localparam logic [15:0] VEC_CAPTURE = 16'hfff6;
  localparam logic [15:0] VEC_COMPARE = 16'hfff4;
  localparam logic [15:0] VEC_OVERFLOW= 16'hfff2;
  localparam logic [15:0] VEC_SERIAL  = 16'hfff0;

  // Flag indices; enable indices 0..3 match, 4 receive, 5 transmit
  localparam int F_STB = 0;
  localparam int F_CAP = 1;
  localparam int F_CMP = 2;
  localparam int F_OVF = 3;
  localparam int F_RXF = 4;
  localparam int F_ORF = 5;
  localparam int F_TXE = 6;
  localparam int N_FLAGS = 7;
  localparam int E_RX = 4;
  localparam int E_TX = 5;
  localparam int N_ENABLES = 6;

  // Status register bit positions
  localparam int B_TM_CAPF = 7;
  localparam int B_TM_CMPF = 6;
  localparam int B_TM_OVFF = 5;
  localparam int B_TM_CAPE = 4;
  localparam int B_TM_CMPE = 3;
  localparam int B_TM_OVFE = 2;
  localparam int B_P3_FLAG = 7;
  localparam int B_P3_EN   = 6;
  localparam int B_SR_RXF  = 7;
  localparam int B_SR_ORF  = 6;
  localparam int B_SR_TXE  = 5;
  localparam int B_SR_RXE  = 4;
  localparam int B_SR_TXEN = 2;

  localparam logic [3:0] ENTRY_CYCLES = 4'd12;
  localparam logic [3:0] GROUP_CYCLE  = 4'd9;
  localparam logic [3:0] SOURCE_CYCLE = 4'd10;
  localparam int CAPTURE_DELAY = 2;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PREPARE = 2'b01,
    ST_SELECT  = 2'b11,
    ST_FINISH  = 2'b10
  } pif_state_e;

  typedef enum logic [2:0] {
    GRP_NONE = 3'h0,
    GRP_NMI  = 3'h1,
    GRP_TRAP = 3'h2,
    GRP_EXT  = 3'h3,
    GRP_INT  = 3'h4
  } pif_group_e;
endpackage : pif_pkg

// >>> rtl/pif_ctrl.sv
module pif_ctrl
  import pif_pkg::*;
#(
  parameter int CAP_DELAY = CAPTURE_DELAY
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        bus_sel,
  input  wire logic        bus_we,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        mask_set,
  input  wire logic        mask_clear,
  input  wire logic        entry_start,
  input  wire logic        entry_trap,
  input  wire logic        nmi_pin_n,
  input  wire logic        ext_req_pin_n,
  input  wire logic        strobe_pin_n,
  input  wire logic        capture_edge,
  input  wire logic        compare_match,
  input  wire logic        count_all_ones,
  input  wire logic        rx_latched,
  input  wire logic        rx_error,
  input  wire logic        tx_loaded,
  output logic             mask_bit,
  output logic             nmi_request,
  output logic             irq_request,
  output logic             entry_active,
  output logic             vector_valid,
  output logic      [15:0] vector_addr
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  logic                 mask_reg;
  logic                 clr_pend_reg;
  logic                 ext_latch_reg;
  logic                 nmi_ff_reg;
  logic                 nmi_prev_reg;
  logic                 stb_prev_reg;
  logic [CAP_DELAY-1:0] cap_dly_reg;
  logic                 cmp_dly_reg;
  logic [N_FLAGS-1:0]   flag_reg;
  logic [N_FLAGS-1:0]   armed_reg;
  logic [N_ENABLES-1:0] en_reg;
  logic [3:0]           cyc_reg;
  pif_state_e           state_reg;
  pif_state_e           state_next;
  pif_group_e           group_reg;
  logic                 trap_reg;
  logic                 irq_reg;
  logic                 vvalid_reg;
  logic                 active_reg;
  logic [15:0]          vector_reg;
  logic [7:0]           rdata_reg;
  logic [7:0]           rd_val;
  logic                 rd;
  logic                 wr;
  logic                 at_source;
  logic                 nmi_fall;
  logic [N_FLAGS-1:0]   en_map;
  logic [N_FLAGS-1:0]   gated;
  logic [N_FLAGS-1:0]   set_ev;
  logic [N_FLAGS-1:0]   arm_ev;
  logic [N_FLAGS-1:0]   clr_ev;

  assign rd        = bus_sel && !bus_we;
  assign wr        = bus_sel && bus_we;
  assign at_source = cyc_reg == SOURCE_CYCLE;
  assign nmi_fall  = nmi_prev_reg && !nmi_pin_n;

  // Both serial receive flags answer to the one receive enable
  assign en_map = {en_reg[E_TX], en_reg[E_RX], en_reg[E_RX], en_reg[F_OVF],
                   en_reg[F_CMP], en_reg[F_CAP], en_reg[F_STB]};
  assign gated  = flag_reg & en_map;

  // Pin edge history; pins are already synchronous
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_prev_reg <= 1'b1;
      stb_prev_reg <= 1'b1;
    end else begin
      nmi_prev_reg <= nmi_pin_n;
      stb_prev_reg <= strobe_pin_n;
    end
  end

  // Timer event alignment
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_dly_reg <= '0;
      cmp_dly_reg <= 1'b0;
    end else begin
      cap_dly_reg <= {cap_dly_reg[CAP_DELAY-2:0], capture_edge};
      cmp_dly_reg <= compare_match;
    end
  end

  assign set_ev[F_STB] = stb_prev_reg && !strobe_pin_n;
  assign set_ev[F_CAP] = cap_dly_reg[CAP_DELAY-1];
  assign set_ev[F_CMP] = cmp_dly_reg;
  assign set_ev[F_OVF] = count_all_ones;
  assign set_ev[F_RXF] = rx_latched;
  assign set_ev[F_ORF] = rx_error;
  assign set_ev[F_TXE] = tx_loaded;

  assign arm_ev[F_STB] = rd && hit(bus_addr, OFS_PORT3_CS);
  assign arm_ev[F_CAP] = rd && hit(bus_addr, OFS_TIMER_CS);
  assign arm_ev[F_CMP] = arm_ev[F_CAP];
  assign arm_ev[F_OVF] = arm_ev[F_CAP];
  assign arm_ev[F_RXF] = rd && hit(bus_addr, OFS_SERIAL_CS);
  assign arm_ev[F_ORF] = arm_ev[F_RXF];
  assign arm_ev[F_TXE] = arm_ev[F_RXF];

  assign clr_ev[F_STB] = bus_sel && hit(bus_addr, OFS_PORT3_VALUE);
  assign clr_ev[F_CAP] = rd && hit(bus_addr, OFS_CAPTURE);
  assign clr_ev[F_CMP] = wr && (hit(bus_addr, OFS_COMPARE_HI) ||
                                hit(bus_addr, OFS_COMPARE_LO));
  assign clr_ev[F_OVF] = rd && hit(bus_addr, OFS_COUNT);
  assign clr_ev[F_RXF] = rd && hit(bus_addr, OFS_RX_BUFFER);
  assign clr_ev[F_ORF] = clr_ev[F_RXF];
  assign clr_ev[F_TXE] = wr && hit(bus_addr, OFS_TX_BUFFER);

  // Per flag: a new event beats a clear and drops arming
  genvar gi;
  generate
    for (gi = 0; gi < N_FLAGS; gi++) begin : g_flag
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          flag_reg[gi]  <= 1'b0;
          armed_reg[gi] <= 1'b0;
        end else if (set_ev[gi]) begin
          flag_reg[gi]  <= 1'b1;
          armed_reg[gi] <= 1'b0;
        end else if (armed_reg[gi] && clr_ev[gi]) begin
          flag_reg[gi]  <= 1'b0;
          armed_reg[gi] <= 1'b0;
        end else if (arm_ev[gi] && flag_reg[gi]) begin
          armed_reg[gi] <= 1'b1;
        end
      end

      flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        armed_reg[gi] && clr_ev[gi] && !set_ev[gi] |=> !flag_reg[gi] && !armed_reg[gi])
        else $error("armed flag did not clear on its access");
      flag_disarm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        set_ev[gi] |=> flag_reg[gi] && !armed_reg[gi])
        else $error("new event left flag armed or clear");
    end
  endgenerate

  // Enables are written in the access cycle itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg <= '0;
    end else if (wr && hit(bus_addr, OFS_TIMER_CS)) begin
      en_reg[F_CAP] <= bus_wdata[B_TM_CAPE];
      en_reg[F_CMP] <= bus_wdata[B_TM_CMPE];
      en_reg[F_OVF] <= bus_wdata[B_TM_OVFE];
    end else if (wr && hit(bus_addr, OFS_PORT3_CS)) begin
      en_reg[F_STB] <= bus_wdata[B_P3_EN];
    end else if (wr && hit(bus_addr, OFS_SERIAL_CS)) begin
      en_reg[E_RX] <= bus_wdata[B_SR_RXE];
      en_reg[E_TX] <= bus_wdata[B_SR_TXEN];
    end
  end

  always_comb begin
    rd_val = '0;
    if (hit(bus_addr, OFS_TIMER_CS)) begin
      rd_val[B_TM_CAPF] = flag_reg[F_CAP];
      rd_val[B_TM_CMPF] = flag_reg[F_CMP];
      rd_val[B_TM_OVFF] = flag_reg[F_OVF];
      rd_val[B_TM_CAPE] = en_reg[F_CAP];
      rd_val[B_TM_CMPE] = en_reg[F_CMP];
      rd_val[B_TM_OVFE] = en_reg[F_OVF];
    end else if (hit(bus_addr, OFS_PORT3_CS)) begin
      rd_val[B_P3_FLAG] = flag_reg[F_STB];
      rd_val[B_P3_EN]   = en_reg[F_STB];
    end else if (hit(bus_addr, OFS_SERIAL_CS)) begin
      rd_val[B_SR_RXF]  = flag_reg[F_RXF];
      rd_val[B_SR_ORF]  = flag_reg[F_ORF];
      rd_val[B_SR_TXE]  = flag_reg[F_TXE];
      rd_val[B_SR_RXE]  = en_reg[E_RX];
      rd_val[B_SR_TXEN] = en_reg[E_TX];
    end
  end

  // Other addresses belong to neighbouring blocks and read zero here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rd ? rd_val : 8'h00;
    end
  end

  // Set always wins, so a clear racing an entry cannot unmask it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg     <= 1'b1;
      clr_pend_reg <= 1'b0;
    end else if (mask_set || at_source) begin
      mask_reg     <= 1'b1;
      clr_pend_reg <= 1'b0;
    end else if (clr_pend_reg) begin
      mask_reg     <= 1'b0;
      clr_pend_reg <= 1'b0;
    end else if (mask_clear) begin
      clr_pend_reg <= 1'b1;
    end
  end

  // External latch only holds while unmasked
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_latch_reg <= 1'b0;
    end else if (mask_reg) begin
      ext_latch_reg <= 1'b0;
    end else if (!ext_req_pin_n) begin
      ext_latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_ff_reg <= 1'b0;
    end else if (nmi_fall) begin
      nmi_ff_reg <= 1'b1;
    end else if (at_source && group_reg == GRP_NMI) begin
      nmi_ff_reg <= 1'b0;
    end
  end

  // Level request, recomputed every cycle so a dropped enable withdraws it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= !mask_reg && (ext_latch_reg || (|gated));
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:    if (entry_start) state_next = ST_PREPARE;
      ST_PREPARE: if (cyc_reg == GROUP_CYCLE - 4'd1) state_next = ST_SELECT;
      ST_SELECT:  if (at_source) state_next = ST_FINISH;
      ST_FINISH:  if (cyc_reg == ENTRY_CYCLES) state_next = ST_IDLE;
      default:    state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= '0;
      trap_reg  <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      active_reg <= state_next != ST_IDLE;
      if (state_reg == ST_IDLE && entry_start) begin
        cyc_reg  <= 4'd1;
        trap_reg <= entry_trap;
      end else if (cyc_reg == ENTRY_CYCLES) begin
        cyc_reg  <= '0;
      end else if (state_reg != ST_IDLE) begin
        cyc_reg  <= cyc_reg + 4'd1;
      end
    end
  end

  // Trap is an instruction, so the mask never stops it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      group_reg <= GRP_NONE;
    end else if (cyc_reg == GROUP_CYCLE) begin
      if (nmi_ff_reg) begin
        group_reg <= GRP_NMI;
      end else if (trap_reg) begin
        group_reg <= GRP_TRAP;
      end else if (ext_latch_reg || gated[F_STB]) begin
        group_reg <= GRP_EXT;
      end else begin
        group_reg <= GRP_INT;
      end
    end else if (state_reg == ST_IDLE) begin
      group_reg <= GRP_NONE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_reg <= VEC_RESET;
      vvalid_reg <= 1'b0;
    end else begin
      vvalid_reg <= at_source;
      if (at_source) begin
        case (group_reg)
          GRP_NMI:  vector_reg <= VEC_NMI;
          GRP_TRAP: vector_reg <= VEC_TRAP;
          GRP_EXT:  vector_reg <= VEC_EXT;
          GRP_INT:  begin
            if (gated[F_CAP]) begin
              vector_reg <= VEC_CAPTURE;
            end else if (gated[F_CMP]) begin
              vector_reg <= VEC_COMPARE;
            end else if (gated[F_OVF]) begin
              vector_reg <= VEC_OVERFLOW;
            end else begin
              vector_reg <= VEC_SERIAL;
            end
          end
          default:  vector_reg <= VEC_RESET;
        endcase
      end
    end
  end

  assign bus_rdata    = rdata_reg;
  assign mask_bit     = mask_reg;
  assign nmi_request  = nmi_ff_reg;
  assign irq_request  = irq_reg;
  assign entry_active = active_reg;
  assign vector_valid = vvalid_reg;
  assign vector_addr  = vector_reg;

  mask_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mask_set |=> mask_reg)
    else $error("mask did not set at once");
  mask_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(mask_reg) |-> $past(mask_clear, 2))
    else $error("mask cleared without a one cycle delay");
  enable_reset_a: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> en_reg == '0 && mask_reg)
    else $error("enables or mask wrong after reset");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_request |-> $past(!mask_reg && (ext_latch_reg || (|gated))))
    else $error("request raised while masked or disabled");
  ext_masked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mask_reg |=> !ext_latch_reg)
    else $error("external latch held while masked");
  nmi_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    nmi_fall |=> nmi_request)
    else $error("falling edge missed by request flip-flop");
  strobe_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(strobe_pin_n) |=> flag_reg[F_STB])
    else $error("strobe edge did not set flag");
  capture_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    capture_edge |-> ##3 flag_reg[F_CAP])
    else $error("capture flag not set two cycles after edge");
  compare_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    compare_match |-> ##2 flag_reg[F_CMP])
    else $error("compare flag not set one cycle after match");
  nmi_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    at_source && group_reg == GRP_NMI && !nmi_fall |=> !nmi_request)
    else $error("request flip-flop not cleared at cycle ten");
  entry_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !entry_active && entry_start |-> ##12 entry_active ##1 !entry_active)
    else $error("entry sequence not twelve cycles");
  source_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    at_source |=> mask_reg && vector_valid)
    else $error("mask or vector missing after cycle ten");
  empty_serial_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    at_source && group_reg == GRP_INT && gated[F_OVF:F_CAP] == '0 |=> vector_addr == VEC_SERIAL)
    else $error("empty internal entry did not pick serial vector");

endmodule : pif_ctrl

// >>> verif/pif_far_model.sv
module pif_far_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [8:0] fire,
  output logic            nmi_pin_n,
  output logic            ext_req_pin_n,
  output logic            strobe_pin_n,
  output logic            capture_edge,
  output logic            compare_match,
  output logic            count_all_ones,
  output logic            rx_latched,
  output logic            rx_error,
  output logic            tx_loaded
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins rest high between events, so each pin event gives a clean falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_pin_n      <= 1'b1;
      ext_req_pin_n  <= 1'b1;
      strobe_pin_n   <= 1'b1;
      capture_edge   <= 1'b0;
      compare_match  <= 1'b0;
      count_all_ones <= 1'b0;
      rx_latched     <= 1'b0;
      rx_error       <= 1'b0;
      tx_loaded      <= 1'b0;
    end else begin
      nmi_pin_n      <= !fire[0];
      ext_req_pin_n  <= !fire[1];
      strobe_pin_n   <= !fire[2];
      capture_edge   <= fire[3];
      compare_match  <= fire[4];
      count_all_ones <= fire[5];
      rx_latched     <= fire[6];
      rx_error       <= fire[7];
      tx_loaded      <= fire[8];
    end
  end
endmodule : pif_far_model

// >>> verif/tb.sv
module tb
  import pif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, rst_n, bus_sel, bus_we, mask_set, mask_clear;
  logic        entry_start, entry_trap;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata;
  logic [8:0]  fire;
  logic        nmi_pin_n, ext_req_pin_n, strobe_pin_n, capture_edge, compare_match;
  logic        count_all_ones, rx_latched, rx_error, tx_loaded;
  logic        mask_bit, nmi_request, irq_request, entry_active, vector_valid;
  logic [15:0] vector_addr;
  int          n_mismatch = 0;
  int          n_checks = 0;

  // Per flag: event, negedges to request, status place and bit, clearing access
  logic [8:0]  ev_bit [7] = '{9'h004, 9'h020, 9'h040, 9'h080, 9'h100, 9'h010, 9'h008};
  int          lag [7] = '{3, 3, 3, 3, 3, 4, 5};
  logic [7:0]  st_addr [7] = '{8'h0f, 8'h08, 8'h11, 8'h11, 8'h11, 8'h08, 8'h08};
  int          st_bit [7] = '{7, 5, 7, 6, 5, 6, 7};
  logic [7:0]  cl_addr [7] = '{8'h06, 8'h09, 8'h12, 8'h12, 8'h13, 8'h0b, 8'h0d};
  logic        cl_we [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [7:0]  en_addr [3] = '{8'h08, 8'h0f, 8'h11};
  logic [7:0]  en_val [3] = '{8'h1c, 8'h40, 8'h14};

  pif_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .bus_sel(bus_sel), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .mask_set(mask_set), .mask_clear(mask_clear), .entry_start(entry_start),
    .entry_trap(entry_trap), .nmi_pin_n(nmi_pin_n), .ext_req_pin_n(ext_req_pin_n),
    .strobe_pin_n(strobe_pin_n), .capture_edge(capture_edge),
    .compare_match(compare_match), .count_all_ones(count_all_ones),
    .rx_latched(rx_latched), .rx_error(rx_error), .tx_loaded(tx_loaded),
    .mask_bit(mask_bit), .nmi_request(nmi_request), .irq_request(irq_request),
    .entry_active(entry_active), .vector_valid(vector_valid), .vector_addr(vector_addr));

  pif_far_model far_u (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire),
    .nmi_pin_n(nmi_pin_n), .ext_req_pin_n(ext_req_pin_n), .strobe_pin_n(strobe_pin_n),
    .capture_edge(capture_edge), .compare_match(compare_match),
    .count_all_ones(count_all_ones), .rx_latched(rx_latched), .rx_error(rx_error),
    .tx_loaded(tx_loaded));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    bus_sel <= 1'b1;
    bus_we <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge sys_clk);
    bus_sel <= 1'b0;
    bus_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    bus_sel <= 1'b1;
    bus_we <= 1'b0;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_sel <= 1'b0;
    @(negedge sys_clk);
    v = bus_rdata;
  endtask : rd

  task automatic clr_access(input int i);
    logic [7:0] d;
    if (cl_we[i]) begin
      wr(cl_addr[i], 8'h00);
    end else begin
      rd(cl_addr[i], d);
    end
  endtask : clr_access

  task automatic fire_ev(input logic [8:0] v);
    @(posedge sys_clk);
    fire <= v;
    @(posedge sys_clk);
    fire <= '0;
  endtask : fire_ev

  task automatic mask_pulse(input logic clr, input logic e1, input logic e2);
    @(posedge sys_clk);
    mask_clear <= clr;
    mask_set <= !clr;
    @(posedge sys_clk);
    mask_clear <= 1'b0;
    mask_set <= 1'b0;
    @(negedge sys_clk);
    chk(mask_bit, e1);
    @(negedge sys_clk);
    chk(mask_bit, e2);
  endtask : mask_pulse

  task automatic entry(input logic trap, input logic [15:0] vec);
    int n;
    @(posedge sys_clk);
    entry_start <= 1'b1;
    entry_trap <= trap;
    @(posedge sys_clk);
    entry_start <= 1'b0;
    entry_trap <= 1'b0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (vector_valid !== 1'b1 && n < 20);
    chk(16'(n), 16'd11);
    chk(vector_addr, vec);
    chk(mask_bit, 1'b1);
    chk(entry_active, 1'b1);
    // Let the twelfth entry cycle pass before anything new starts
    repeat (3) @(negedge sys_clk);
    chk(entry_active, 1'b0);
    chk(vector_valid, 1'b0);
  endtask : entry

  initial begin
    #(50ns * 4000);
    n_mismatch++;
    conclude();
  end

  initial begin
    int i;
    int n;
    logic [7:0] d;
    {bus_sel, bus_we, mask_set, mask_clear, entry_start, entry_trap} = '0;
    bus_addr = '0;
    bus_wdata = '0;
    fire = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk(mask_bit, 1'b1);
    chk(vector_addr, VEC_RESET);
    for (i = 0; i < 3; i++) begin
      rd(en_addr[i], d);
      chk(d, 8'h00);
      wr(en_addr[i], en_val[i]);
      rd(en_addr[i], d);
      chk(d, en_val[i]);
    end
    rd(8'h20, d);
    chk(d, 8'h00);
    $display("test registers done");
    mask_pulse(1'b1, 1'b1, 1'b0);
    mask_pulse(1'b0, 1'b1, 1'b1);
    mask_pulse(1'b1, 1'b1, 1'b0);
    $display("test mask timing done");
    for (i = 0; i < 7; i++) begin
      fire_ev(ev_bit[i]);
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (irq_request !== 1'b1 && n < 12);
      chk(irq_request, 1'b1);
      chk(16'(n), 16'(lag[i]));
      // Clearing access before arming must leave the flag alone
      clr_access(i);
      rd(st_addr[i], d);
      chk(d[st_bit[i]], 1'b1);
      clr_access(i);
      rd(st_addr[i], d);
      chk(d[st_bit[i]], 1'b0);
      repeat (2) @(negedge sys_clk);
      chk(irq_request, 1'b0);
    end
    // A second strobe after arming must survive the clearing access
    fire_ev(9'h004);
    repeat (2) @(negedge sys_clk);
    rd(8'h0f, d);
    fire_ev(9'h004);
    repeat (2) @(negedge sys_clk);
    rd(8'h06, d);
    rd(8'h0f, d);
    chk(d[7], 1'b1);
    rd(8'h06, d);
    rd(8'h0f, d);
    chk(d[7], 1'b0);
    $display("test flags done");
    mask_pulse(1'b0, 1'b1, 1'b1);
    entry(1'b1, VEC_TRAP);
    mask_pulse(1'b1, 1'b1, 1'b0);
    fire_ev(9'h038);
    repeat (4) @(negedge sys_clk);
    entry(1'b0, VEC_CAPTURE);
    wr(8'h08, 8'h0c);
    entry(1'b0, VEC_COMPARE);
    chk(irq_request, 1'b0);
    wr(8'h08, 8'h00);
    entry(1'b0, VEC_SERIAL);
    mask_pulse(1'b1, 1'b1, 1'b0);
    fire_ev(9'h002);
    repeat (4) @(negedge sys_clk);
    chk(irq_request, 1'b1);
    entry(1'b0, VEC_EXT);
    fire_ev(9'h001);
    repeat (3) @(negedge sys_clk);
    chk(nmi_request, 1'b1);
    entry(1'b0, VEC_NMI);
    chk(nmi_request, 1'b0);
    $display("test entry done");
    conclude();
  end
endmodule : tb
